// File: hw/power_gating_interval_timer.sv
// Long interval timer driving a power gate with calibration pulse
`timescale 1ns/10ps

// Function
// - Power-good low while off: clear, stay off
// - Power-good low while on: gate high now
// - Re-enable only after full delay past recovery
// - Power-good rise starts oscillator and new count
// - Delay expiry drives gate low, then cal
// - Cal one period, half period after gate
// - Done during gate: reset counter, idle pins
// - No done: gate low two periods exactly
// - Done during cal: reset, cal low at once
// - Power-good fall asynchronously idles both pins
// - Three select bits choose among eight intervals
// - Delay equals base period times factor N
module power_gating_interval_timer #(
    parameter int HALF_PERIOD_CYCLES = interval_timer_pkg::HALF_PERIOD_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic power_good_in,
    input  wire logic done_in,
    input  wire logic interval_sel_0,
    input  wire logic interval_sel_1,
    input  wire logic interval_sel_2,
    output logic      gate_drive_n,
    output logic      cal_pulse_out
);

    // ****************************************************************
    // Delay decode
    // ****************************************************************
    // Half periods in a full delay for one select code
    function automatic logic [interval_timer_pkg::CNT_W-1:0] delay_halves(
        input logic [2:0] sel
    );
        int factor;
        factor = interval_timer_pkg::FACTOR_16S;
        unique case (sel)
            3'h0: factor = interval_timer_pkg::FACTOR_16S;
            3'h1: factor = interval_timer_pkg::FACTOR_32S;
            3'h2: factor = interval_timer_pkg::FACTOR_64S;
            3'h3: factor = interval_timer_pkg::FACTOR_100S;
            3'h4: factor = interval_timer_pkg::FACTOR_128S;
            3'h5: factor = interval_timer_pkg::FACTOR_256S;
            3'h6: factor = interval_timer_pkg::FACTOR_512S;
            3'h7: factor = interval_timer_pkg::FACTOR_1024S;
        endcase
        return interval_timer_pkg::CNT_W'(factor * 2);
    endfunction

    localparam logic [interval_timer_pkg::DIV_W-1:0] DIV_LAST =
        interval_timer_pkg::DIV_W'(HALF_PERIOD_CYCLES - 1);

    interval_timer_pkg::timer_state_t        state;
    interval_timer_pkg::timer_state_t        next_state;
    interval_timer_pkg::pulse_pins_t         pins;
    interval_timer_pkg::pulse_pins_t         next_pins;
    logic [interval_timer_pkg::DIV_W-1:0]    div;
    logic [interval_timer_pkg::DIV_W-1:0]    next_div;
    logic [interval_timer_pkg::CNT_W-1:0]    cnt;
    logic [interval_timer_pkg::CNT_W-1:0]    next_cnt;
    logic [interval_timer_pkg::CNT_W-1:0]    limit;
    logic [2:0]                              sel;
    logic                                    half_tick;
    logic                                    in_off;
    logic                                    in_count;
    logic                                    in_pulse;
    logic                                    expire;
    logic                                    done_hit;
    logic                                    pulse_end;
    logic                                    restart;

    assign sel       = {interval_sel_2, interval_sel_1, interval_sel_0};
    assign limit     = delay_halves(sel);
    assign in_off    = (state == interval_timer_pkg::ST_OFF);
    assign in_count  = (state == interval_timer_pkg::ST_COUNT);
    assign in_pulse  = (state == interval_timer_pkg::ST_PULSE);
    assign half_tick = !in_off && (div == DIV_LAST);
    assign expire    = in_count && half_tick && (cnt >= limit - 18'h00001);
    // Done acts on the gate pulse and on a high cal pin, which never stays high after the gate ends
    assign done_hit  = done_in && (in_pulse || pins.cal_pulse_out);
    assign pulse_end = in_pulse && half_tick
                       && (cnt == interval_timer_pkg::GATE_LAST_STEP);
    assign restart   = done_hit || pulse_end || in_off;

    // ****************************************************************
    // Oscillator model: half period tick, frozen while off
    // ****************************************************************
    assign next_div = (restart || half_tick) ? '0 : div + 18'h00001;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_pins  = pins;
        unique case (state)
            interval_timer_pkg::ST_OFF: begin
                // Reached only with power-good high, i.e. just after its rise or after rst_n release
                next_state = interval_timer_pkg::ST_COUNT;
                next_cnt   = '0;
            end
            interval_timer_pkg::ST_COUNT: begin
                if (done_hit) begin
                    next_pins.cal_pulse_out = interval_timer_pkg::CAL_IDLE;
                    next_cnt                = '0;
                end else if (expire) begin
                    next_state             = interval_timer_pkg::ST_PULSE;
                    next_cnt               = '0;
                    next_pins.gate_drive_n = 1'b0;
                end else if (half_tick) begin
                    next_cnt = cnt + 18'h00001;
                end
            end
            interval_timer_pkg::ST_PULSE: begin
                if (done_hit || pulse_end) begin
                    next_state = interval_timer_pkg::ST_COUNT;
                    next_cnt   = '0;
                    next_pins  = '{gate_drive_n: interval_timer_pkg::GATE_IDLE,
                                   cal_pulse_out: interval_timer_pkg::CAL_IDLE};
                end else if (half_tick) begin
                    next_cnt = cnt + 18'h00001;
                    if (cnt == interval_timer_pkg::CAL_RISE_STEP)
                        next_pins.cal_pulse_out = 1'b1;
                    if (cnt == interval_timer_pkg::CAL_FALL_STEP)
                        next_pins.cal_pulse_out = 1'b0;
                end
            end
        endcase
    end

    // Power-good low clears everything at once and stops the oscillator
    always_ff @(posedge clk or negedge power_good_in) begin
        if (!power_good_in) begin
            state <= interval_timer_pkg::ST_OFF;
            cnt   <= '0;
            div   <= '0;
            pins  <= '{gate_drive_n: interval_timer_pkg::GATE_IDLE,
                       cal_pulse_out: interval_timer_pkg::CAL_IDLE};
        end else if (!rst_n) begin
            state <= interval_timer_pkg::ST_OFF;
            cnt   <= '0;
            div   <= '0;
            pins  <= '{gate_drive_n: interval_timer_pkg::GATE_IDLE,
                       cal_pulse_out: interval_timer_pkg::CAL_IDLE};
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            div   <= next_div;
            pins  <= next_pins;
        end
    end

    assign gate_drive_n  = pins.gate_drive_n;
    assign cal_pulse_out = pins.cal_pulse_out;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_pg_low_idle: assert property (@(posedge clk)
        disable iff (!rst_n)
        !power_good_in |-> gate_drive_n && !cal_pulse_out && in_off)
        else $error("pins not idle while power-good low");

    a_pg_fall_off: assert property (@(posedge clk)
        disable iff (!rst_n)
        $fell(power_good_in) |-> gate_drive_n && cnt == '0)
        else $error("gate still driven after power-good fall");

    a_off_stays: assert property (@(posedge clk)
        disable iff (!rst_n)
        in_off |=> gate_drive_n && (in_off || cnt == '0))
        else $error("gate driven before a new delay");

    // Both levels sampled high, so the very next edge leaves the off state
    a_restart_count: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        in_off && rst_n && power_good_in |=> in_count && cnt == '0 && div == '0)
        else $error("count not restarted on power-good rise");

    a_gate_expiry: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        in_count && half_tick && !done_hit && cnt == limit - 18'h00001
        |=> !gate_drive_n && !cal_pulse_out && in_pulse)
        else $error("gate not driven at delay expiry");

    a_gate_early: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        $fell(gate_drive_n) |-> $past(cnt) == limit - 18'h00001)
        else $error("gate driven before full delay");

    a_cal_rise: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        in_pulse && half_tick && !done_in && cnt == 18'h00000 |=> cal_pulse_out)
        else $error("cal pulse did not start half period after gate");

    // A tick-driven fall two ticks after the rise makes the width one period
    a_cal_fall: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        $fell(cal_pulse_out) && in_pulse
        |-> cnt == interval_timer_pkg::GATE_LAST_STEP && div == '0)
        else $error("cal pulse misplaced");

    a_done_release: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        done_in && in_pulse |=> gate_drive_n && !cal_pulse_out && in_count && cnt == '0)
        else $error("done did not release gate");

    a_auto_release: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        pulse_end && !done_in |=> gate_drive_n && in_count && cnt == '0)
        else $error("gate not released after two periods");

    a_done_cal: assert property (@(posedge clk)
        disable iff (!rst_n || !power_good_in)
        done_in && cal_pulse_out |=> !cal_pulse_out)
        else $error("cal not cleared by done");

    c_done_pulse: cover property (@(posedge clk) disable iff (!rst_n)
        in_pulse && done_in ##1 in_count);
    c_auto_end: cover property (@(posedge clk) disable iff (!rst_n)
        pulse_end && !done_in);
    c_pg_drop_on: cover property (@(posedge clk) disable iff (!rst_n)
        !gate_drive_n ##1 !power_good_in);
    c_cal_high: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(cal_pulse_out));

endmodule

// File: shared/interval_timer_pkg.sv
// Constants and types shared by the power gating interval timer
package interval_timer_pkg;

    // ****************************************************************
    // Timebase
    // ****************************************************************
    localparam int CLK_HZ        = 20_000_000;
    // Base oscillator period, in microseconds (15.625 ms)
    localparam int OSC_PERIOD_US = 15_625;
    // Work is done in half periods, since the pulse edges sit on half steps
    localparam int HALF_PERIOD_CYCLES = ((CLK_HZ / 1_000_000) * OSC_PERIOD_US) / 2;

    localparam int DIV_W = 18;
    localparam int CNT_W = 18;

    // ****************************************************************
    // Delay factors, in whole oscillator periods
    // ****************************************************************
    localparam int FACTOR_16S   = 1 << 10;
    localparam int FACTOR_32S   = 1 << 11;
    localparam int FACTOR_64S   = 1 << 12;
    localparam int FACTOR_100S  = 100 * (1 << 6);
    localparam int FACTOR_128S  = 1 << 13;
    localparam int FACTOR_256S  = 1 << 14;
    localparam int FACTOR_512S  = 1 << 15;
    localparam int FACTOR_1024S = 1 << 16;

    // ****************************************************************
    // Gate pulse shape, as the count at the acting tick (half periods after the gate falls, minus one)
    // ****************************************************************
    localparam logic [CNT_W-1:0] CAL_RISE_STEP  = 18'h00000;
    localparam logic [CNT_W-1:0] CAL_FALL_STEP  = 18'h00002;
    localparam logic [CNT_W-1:0] GATE_LAST_STEP = 18'h00003;

    // ****************************************************************
    // Reset values of the pins
    // ****************************************************************
    localparam logic GATE_IDLE = 1'b1;
    localparam logic CAL_IDLE  = 1'b0;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b001,
        ST_COUNT = 3'b010,
        ST_PULSE = 3'b100
    } timer_state_t;

    typedef struct packed {
        logic gate_drive_n;
        logic cal_pulse_out;
    } pulse_pins_t;

endpackage

// File: tb/gated_ctrl_model.sv
// Behavioural model of the controller that sits behind the power gate
`timescale 1ns/10ps
module gated_ctrl_model (
    input  wire logic        clk,
    input  wire logic        gate_drive_n,
    input  wire logic        cal_pulse_out,
    input  wire logic        done_en,
    input  wire logic [7:0]  done_delay,
    output logic             done_in,
    output logic [15:0]      cal_width
);
    logic [15:0] on_cnt  = 16'h0000;
    logic [15:0] cal_cnt = 16'h0000;

    initial done_in = 1'b0;
    initial cal_width = 16'h0000;

    // Unpowered controller leaves done low through its pull-down
    always @(posedge clk) begin
        if (gate_drive_n) begin
            on_cnt  <= 16'h0000;
            done_in <= 1'b0;
        end else begin
            on_cnt  <= on_cnt + 16'h0001;
            done_in <= done_en && (on_cnt == {8'h00, done_delay});
        end
    end

    // Crystal-timed width of the calibration pulse
    // Measured on every pulse here; a real controller would only do so
    // under fast temperature swings
    always @(posedge clk) begin
        if (cal_pulse_out) begin
            cal_cnt <= cal_cnt + 16'h0001;
        end else if (cal_cnt != 16'h0000) begin
            cal_width <= cal_cnt;
            cal_cnt   <= 16'h0000;
        end
    end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the power gating interval timer
`timescale 1ns/10ps
module tb_top;
    localparam int H   = 4;
    localparam int D16 = 2 * interval_timer_pkg::FACTOR_16S * H;
    localparam int D32 = 2 * interval_timer_pkg::FACTOR_32S * H;
    logic        clk           = 1'b0;
    logic        rst_n         = 1'b0;
    logic        power_good_in = 1'b0;
    logic [2:0]  sel           = 3'h0;
    logic        done_en       = 1'b0;
    logic        done_in;
    logic        gate_drive_n;
    logic        cal_pulse_out;
    logic [15:0] cal_width;
    int          error_cnt     = 0;
    int          checks        = 0;
    int          cycles        = 0;

    always #25 clk = ~clk;

    power_gating_interval_timer #(.HALF_PERIOD_CYCLES(H)) u_power_gating_interval_timer (
        .clk(clk), .rst_n(rst_n), .power_good_in(power_good_in), .done_in(done_in),
        .interval_sel_0(sel[0]), .interval_sel_1(sel[1]), .interval_sel_2(sel[2]),
        .gate_drive_n(gate_drive_n), .cal_pulse_out(cal_pulse_out));

    gated_ctrl_model u_gated_ctrl_model (
        .clk(clk), .gate_drive_n(gate_drive_n), .cal_pulse_out(cal_pulse_out),
        .done_en(done_en), .done_delay(8'h06), .done_in(done_in), .cal_width(cal_width));

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Ceiling covers about 70k cycles of planned traffic
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            error_cnt++;
            close_out();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task wait_on(input logic which, input logic val, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((which ? cal_pulse_out : gate_drive_n) !== val && n < D32 + 100);
    endtask

    // Whole delay plus an unacknowledged pulse, timed edge by edge
    task auto_pulse(input int d);
        int n;
        wait_on(1'b0, 1'b0, n);
        chk_rng(n, d - 3, d + 3);
        wait_on(1'b1, 1'b1, n);
        chk(n, H);
        wait_on(1'b1, 1'b0, n);
        chk(n, 2 * H);
        wait_on(1'b0, 1'b1, n);
        chk(n, H);
        chk({16'h0000, cal_width}, 2 * H);
    endtask

    task t_power_up();
        @(posedge clk);
        power_good_in <= 1'b1;
        auto_pulse(D16);
    endtask

    task t_done();
        int n;
        @(posedge clk);
        done_en <= 1'b1;
        wait_on(1'b0, 1'b0, n);
        chk_rng(n, D16 - 3, D16 + 3);
        wait_on(1'b0, 1'b1, n);
        chk(n, 8);
        chk(cal_pulse_out, 1'b0);
        @(posedge clk);
        done_en <= 1'b0;
    endtask

    // Drop power-good while the controller is powered and cal is high
    task t_drop_on();
        int n;
        wait_on(1'b1, 1'b1, n);
        @(posedge clk);
        power_good_in <= 1'b0;
        #1;
        chk(gate_drive_n, 1'b1);
        chk(cal_pulse_out, 1'b0);
        repeat (20) @(posedge clk);
        power_good_in <= 1'b1;
        auto_pulse(D16);
    endtask

    task t_drop_off();
        repeat (3000) @(posedge clk);
        power_good_in <= 1'b0;
        repeat (20) @(posedge clk);
        power_good_in <= 1'b1;
        #1;
        chk(gate_drive_n, 1'b1);
        auto_pulse(D16);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        auto_pulse(D16);
        t_done();
        t_drop_on();
        t_drop_off();
        @(posedge clk);
        sel <= 3'h1;
        auto_pulse(D32);
        close_out();
    end
endmodule
